// ==== core/fault_flag_pkg.sv ====
package fault_flag_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_BANKS = 3;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] LIVE_CH_A_OFS   = 16'hfec0;
  localparam logic [ADDR_W-1:0] LIVE_CH_B_OFS   = 16'hfec1;
  localparam logic [ADDR_W-1:0] LIVE_SYS_OFS    = 16'hfec2;
  localparam logic [ADDR_W-1:0] LATCH_CH_A_OFS  = 16'hfec5;
  localparam logic [ADDR_W-1:0] LATCH_CH_B_OFS  = 16'hfec6;
  localparam logic [ADDR_W-1:0] LATCH_SYS_OFS   = 16'hfec7;
  localparam logic [ADDR_W-1:0] PG_CFG_OFS      = 16'hfed0;

  // ==========================================================
  // bank indices
  localparam int BANK_CH_A = 0;
  localparam int BANK_CH_B = 1;
  localparam int BANK_SYS  = 2;

  // ==========================================================
  // channel flag bit positions
  localparam int CH_OFF_BIT     = 7;
  localparam int CH_PG_BIT      = 6;
  localparam int CH_OC1_BIT     = 5;
  localparam int CH_OC2_BIT     = 4;
  localparam int CH_UV_BIT      = 3;
  localparam int CH_OV_BIT      = 2;
  localparam int CH_LL_BIT      = 1;
  localparam int CH_REF_BIT     = 0;

  // ==========================================================
  // system flag bit positions
  localparam int SYS_RSVD_BIT   = 7;
  localparam int SYS_SUPPLY_OVERVOLTAGE_BIT = 6;
  localparam int SYS_OC_BIT     = 5;
  localparam int SYS_OT2_BIT    = 4;
  localparam int SYS_OT1_BIT    = 3;
  localparam int SYS_AC_BIT     = 2;
  localparam int SYS_CRC_BIT    = 1;
  localparam int SYS_EXT_BIT    = 0;

  // ==========================================================
  // power-good option register layout
  localparam int PG_CFG_W          = 4;
  localparam int PG_CFG_AC_A_BIT   = 0;
  localparam int PG_CFG_WARN_A_BIT = 1;
  localparam int PG_CFG_AC_B_BIT   = 2;
  localparam int PG_CFG_WARN_B_BIT = 3;
  localparam logic [PG_CFG_W-1:0] PG_CFG_RESET = 4'h0;

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_NONE  = 8'h00;

endpackage : fault_flag_pkg

// ==== core/fault_flag_status_bank.sv ====
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module fault_flag_status_bank
  import fault_flag_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // channel A conditions
  input  wire logic              shutdown_ch_a_i,
  input  wire logic              primary_overcurrent_ch_a_i,
  input  wire logic              secondary_overcurrent_ch_a_i,
  input  wire logic              undervoltage_ch_a_i,
  input  wire logic              overvoltage_ch_a_i,
  input  wire logic              light_load_ch_a_i,
  input  wire logic              reference_range_error_ch_a_i,
  input  wire logic              softstart_filter_active_ch_a_i,
  // channel B conditions
  input  wire logic              shutdown_ch_b_i,
  input  wire logic              primary_overcurrent_ch_b_i,
  input  wire logic              secondary_overcurrent_ch_b_i,
  input  wire logic              undervoltage_ch_b_i,
  input  wire logic              overvoltage_ch_b_i,
  input  wire logic              light_load_ch_b_i,
  input  wire logic              reference_range_error_ch_b_i,
  input  wire logic              softstart_filter_active_ch_b_i,
  // system conditions
  input  wire logic              supply_overvoltage_i,
  input  wire logic              shared_overcurrent_i,
  input  wire logic              overtemp_zone1_i,
  input  wire logic              overtemp_zone2_i,
  input  wire logic              temp_warning_zone1_i,
  input  wire logic              temp_warning_zone2_i,
  input  wire logic              ac_line_sense_low_i,
  input  wire logic              eeprom_checksum_error_i,
  input  wire logic              external_flag_sync_pin_i,
  // power-on commands
  input  wire logic              power_on_command_i,
  input  wire logic              power_on_command_ch_a_i,
  input  wire logic              power_on_command_ch_b_i,
  // pins and actions
  output logic                   power_good_fault_ch_a_n_o,
  output logic                   power_good_fault_ch_b_n_o,
  output logic                   immediate_shutdown_o,
  output logic                   restart_inhibit_o
);

  // ==========================================================
  // declarations
  logic [DATA_W-1:0]   live_d      [NUM_BANKS];
  logic [DATA_W-1:0]   live_q      [NUM_BANKS];
  logic [DATA_W-1:0]   latch_d     [NUM_BANKS];
  logic [DATA_W-1:0]   latch_q     [NUM_BANKS];
  logic [NUM_BANKS-1:0] latch_rd_hit;
  logic [PG_CFG_W-1:0] pg_cfg_q;
  logic [DATA_W-1:0]   rdata_q;
  logic                ext_s1_q;
  logic                ext_s2_q;
  logic                ext_s3_q;
  logic                external_flag_input_q;
  logic                off_ch_a_q;
  logic                off_ch_b_q;
  logic                pon_prev_q;
  logic                inhibit_q;
  logic                power_good_fault_ch_a;
  logic                power_good_fault_ch_b;

  // ==========================================================
  // external flag pin synchroniser
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_flag_sync_pin_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // accept a change only once two stages agree
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      external_flag_input_q <= 1'b0;
    end else if (ext_s2_q == ext_s3_q) begin
      external_flag_input_q <= ext_s3_q;
    end
  end

  // ==========================================================
  // channel off flags
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      off_ch_a_q <= 1'b0;
    end else if (shutdown_ch_a_i || eeprom_checksum_error_i) begin
      off_ch_a_q <= 1'b1;
    end else if (power_on_command_ch_a_i) begin
      off_ch_a_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      off_ch_b_q <= 1'b0;
    end else if (shutdown_ch_b_i || eeprom_checksum_error_i) begin
      off_ch_b_q <= 1'b1;
    end else if (power_on_command_ch_b_i) begin
      off_ch_b_q <= 1'b0;
    end
  end

  // ==========================================================
  // power-good fault terms
  always_comb begin
    power_good_fault_ch_a = undervoltage_ch_a_i | off_ch_a_q
                          | eeprom_checksum_error_i
                          | softstart_filter_active_ch_a_i
                          | (pg_cfg_q[PG_CFG_AC_A_BIT] & ac_line_sense_low_i)
                          | (pg_cfg_q[PG_CFG_WARN_A_BIT] & temp_warning_zone1_i);
    power_good_fault_ch_b = undervoltage_ch_b_i | off_ch_b_q
                          | eeprom_checksum_error_i
                          | softstart_filter_active_ch_b_i
                          | (pg_cfg_q[PG_CFG_AC_B_BIT] & ac_line_sense_low_i)
                          | (pg_cfg_q[PG_CFG_WARN_B_BIT] & temp_warning_zone2_i);
  end

  // ==========================================================
  // live flag next values
  always_comb begin
    live_d[BANK_CH_A]              = FLAGS_RESET;
    live_d[BANK_CH_A][CH_OFF_BIT]  = off_ch_a_q;
    live_d[BANK_CH_A][CH_PG_BIT]   = power_good_fault_ch_a;
    live_d[BANK_CH_A][CH_OC1_BIT]  = primary_overcurrent_ch_a_i;
    live_d[BANK_CH_A][CH_OC2_BIT]  = secondary_overcurrent_ch_a_i;
    live_d[BANK_CH_A][CH_UV_BIT]   = undervoltage_ch_a_i;
    live_d[BANK_CH_A][CH_OV_BIT]   = overvoltage_ch_a_i;
    live_d[BANK_CH_A][CH_LL_BIT]   = light_load_ch_a_i;
    live_d[BANK_CH_A][CH_REF_BIT]  = reference_range_error_ch_a_i;
    live_d[BANK_CH_B]              = FLAGS_RESET;
    live_d[BANK_CH_B][CH_OFF_BIT]  = off_ch_b_q;
    live_d[BANK_CH_B][CH_PG_BIT]   = power_good_fault_ch_b;
    live_d[BANK_CH_B][CH_OC1_BIT]  = primary_overcurrent_ch_b_i;
    live_d[BANK_CH_B][CH_OC2_BIT]  = secondary_overcurrent_ch_b_i;
    live_d[BANK_CH_B][CH_UV_BIT]   = undervoltage_ch_b_i;
    live_d[BANK_CH_B][CH_OV_BIT]   = overvoltage_ch_b_i;
    live_d[BANK_CH_B][CH_LL_BIT]   = light_load_ch_b_i;
    live_d[BANK_CH_B][CH_REF_BIT]  = reference_range_error_ch_b_i;
    live_d[BANK_SYS]                = FLAGS_RESET;
    live_d[BANK_SYS][SYS_SUPPLY_OVERVOLTAGE_BIT] = supply_overvoltage_i;
    live_d[BANK_SYS][SYS_OC_BIT]     = shared_overcurrent_i;
    live_d[BANK_SYS][SYS_OT2_BIT]    = overtemp_zone2_i;
    live_d[BANK_SYS][SYS_OT1_BIT]    = overtemp_zone1_i;
    live_d[BANK_SYS][SYS_AC_BIT]     = ac_line_sense_low_i;
    live_d[BANK_SYS][SYS_CRC_BIT]    = eeprom_checksum_error_i;
    live_d[BANK_SYS][SYS_EXT_BIT]    = external_flag_input_q;
  end

  // ==========================================================
  // latched read decode
  always_comb begin
    latch_rd_hit            = '0;
    latch_rd_hit[BANK_CH_A] = reg_rd_i && (reg_addr_i == LATCH_CH_A_OFS);
    latch_rd_hit[BANK_CH_B] = reg_rd_i && (reg_addr_i == LATCH_CH_B_OFS);
    latch_rd_hit[BANK_SYS]  = reg_rd_i && (reg_addr_i == LATCH_SYS_OFS);
  end

  // ==========================================================
  // live and latched banks
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    // rising edge sets, a read clears only bits whose fault is gone, power-on command clears all but bits rising that cycle
    assign latch_d[b] = (live_d[b] & ~live_q[b])
                      | (latch_q[b]
                         & ~(({DATA_W{latch_rd_hit[b]}} & ~live_q[b])
                             | {DATA_W{power_on_command_i}}));

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        live_q[b] <= FLAGS_RESET;
      end else begin
        live_q[b] <= live_d[b];
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        latch_q[b] <= FLAGS_RESET;
      end else begin
        latch_q[b] <= latch_d[b];
      end
    end
  end

  // ==========================================================
  // power-good option register, the only writable one
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pg_cfg_q <= PG_CFG_RESET;
    end else if (reg_wr_i && (reg_addr_i == PG_CFG_OFS)) begin
      pg_cfg_q <= reg_wdata_i[PG_CFG_W-1:0];
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= RDATA_NONE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        LIVE_CH_A_OFS:  rdata_q <= live_q[BANK_CH_A];
        LIVE_CH_B_OFS:  rdata_q <= live_q[BANK_CH_B];
        LIVE_SYS_OFS:   rdata_q <= live_q[BANK_SYS];
        LATCH_CH_A_OFS: rdata_q <= latch_q[BANK_CH_A];
        LATCH_CH_B_OFS: rdata_q <= latch_q[BANK_CH_B];
        LATCH_SYS_OFS:  rdata_q <= latch_q[BANK_SYS];
        PG_CFG_OFS:     rdata_q <= {{(DATA_W-PG_CFG_W){1'b0}}, pg_cfg_q};
        default:        rdata_q <= RDATA_NONE;
      endcase
    end else begin
      rdata_q <= RDATA_NONE;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ==========================================================
  // supply overvoltage restart interlock
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pon_prev_q <= 1'b0;
    end else begin
      pon_prev_q <= power_on_command_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      inhibit_q <= 1'b0;
    end else if (live_q[BANK_SYS][SYS_SUPPLY_OVERVOLTAGE_BIT]) begin
      inhibit_q <= 1'b1;
    end else if (power_on_command_i != pon_prev_q) begin
      inhibit_q <= 1'b0;
    end
  end

  // ==========================================================
  // pin drive
  assign power_good_fault_ch_a_n_o = ~live_q[BANK_CH_A][CH_PG_BIT];
  assign power_good_fault_ch_b_n_o = ~live_q[BANK_CH_B][CH_PG_BIT];
  assign immediate_shutdown_o      = live_q[BANK_SYS][SYS_CRC_BIT];
  assign restart_inhibit_o         = inhibit_q;

endmodule : fault_flag_status_bank

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
// ========================================
// host software side of the register port
module host_model
  import fault_flag_pkg::*;
(
  // clock
  input  wire logic              core_clk_i,
  // register port
  output logic      [ADDR_W-1:0] reg_addr_o,
  output logic      [DATA_W-1:0] reg_wdata_o,
  output logic                   reg_wr_o,
  output logic                   reg_rd_o,
  input  wire logic [DATA_W-1:0] reg_rdata_i
);
  initial {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;

  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    reg_rd_o   <= 1'h1;
    reg_addr_o <= a;
    @(posedge core_clk_i);
    reg_rd_o   <= 1'h0;
    reg_addr_o <= ~a;
    #1 d = reg_rdata_i;
  endtask : rd

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge core_clk_i);
    reg_wr_o    <= 1'h1;
    reg_addr_o  <= a;
    reg_wdata_o <= v;
    @(posedge core_clk_i);
    reg_wr_o    <= 1'h0;
    reg_wdata_o <= ~v;
  endtask : wr
endmodule : host_model

// ==== sim/fault_flag_status_bank_asserts.sv ====
`timescale 1ns/1ps
// ========================================
// port checks for the flag bank
module fault_flag_status_bank_asserts
  import fault_flag_pkg::*;
(
  // clock and reset
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic              reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // conditions
  input wire logic              primary_overcurrent_ch_a_i,
  input wire logic              undervoltage_ch_a_i,
  input wire logic              undervoltage_ch_b_i,
  input wire logic              eeprom_checksum_error_i,
  input wire logic              supply_overvoltage_i,
  input wire logic              power_on_command_i,
  // outputs
  input wire logic              power_good_fault_ch_a_n_o,
  input wire logic              power_good_fault_ch_b_n_o,
  input wire logic              immediate_shutdown_o,
  input wire logic              restart_inhibit_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  chk_live_oc_a: assert property (
    reg_rd_i && reg_addr_i == LIVE_CH_A_OFS && !$past(rst_i)
    |=> reg_rdata_o[CH_OC1_BIT] == $past(primary_overcurrent_ch_a_i, 2)) else $error("live overcurrent a wrong");
  chk_live_uv_b: assert property (
    reg_rd_i && reg_addr_i == LIVE_CH_B_OFS && !$past(rst_i)
    |=> reg_rdata_o[CH_UV_BIT] == $past(undervoltage_ch_b_i, 2)) else $error("live undervoltage b wrong");
  chk_sys_rsvd: assert property (
    reg_rd_i && (reg_addr_i == LIVE_SYS_OFS || reg_addr_i == LATCH_SYS_OFS)
    |=> !reg_rdata_o[SYS_RSVD_BIT]) else $error("reserved bit set");
  chk_power_good_fault_ch_a_low: assert property (
    (!rst_i && undervoltage_ch_a_i) [*3] |-> !power_good_fault_ch_a_n_o) else $error("pin a not low");
  chk_power_good_fault_ch_b_low: assert property (
    (!rst_i && undervoltage_ch_b_i) [*3] |-> !power_good_fault_ch_b_n_o) else $error("pin b not low");
  chk_shutdown_on: assert property (
    (!rst_i && eeprom_checksum_error_i) [*3] |-> immediate_shutdown_o) else $error("no shutdown");
  chk_inhibit_set: assert property (
    (!rst_i && supply_overvoltage_i) [*3] |-> restart_inhibit_o) else $error("no restart inhibit");
  chk_inhibit_hold: assert property (
    restart_inhibit_o && $stable(power_on_command_i) |=> restart_inhibit_o) else $error("inhibit lost");
  chk_rdata_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == RDATA_NONE) else $error("read data outside read cycle");
endmodule : fault_flag_status_bank_asserts

bind fault_flag_status_bank fault_flag_status_bank_asserts u_chk (
  .core_clk_i, .rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .primary_overcurrent_ch_a_i,
  .undervoltage_ch_a_i, .undervoltage_ch_b_i, .eeprom_checksum_error_i, .supply_overvoltage_i,
  .power_on_command_i, .power_good_fault_ch_a_n_o, .power_good_fault_ch_b_n_o,
  .immediate_shutdown_o, .restart_inhibit_o);

// ==== sim/fault_flag_status_bank_test.sv ====
`timescale 1ns/1ps
module fault_flag_status_bank_test import fault_flag_pkg::*;;
  // ========================================
  // stimulus and model state
  logic              core_clk_i, rst_i, reg_wr_i, reg_rd_i, pon, pon_a, pon_b, w1, w2;
  logic              shut, inh, off_a, off_b, inh_m;
  logic [1:0]        pg_n;
  logic [3:0]        cfg;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, d, ca, cb, sy, lv[3], lat[3];
  int                fails, total_checks, seed;

  initial begin
    core_clk_i = 1'h0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  fault_flag_status_bank dut (
    .core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .shutdown_ch_a_i(ca[7]), .softstart_filter_active_ch_a_i(ca[6]), .primary_overcurrent_ch_a_i(ca[5]),
    .secondary_overcurrent_ch_a_i(ca[4]), .undervoltage_ch_a_i(ca[3]), .overvoltage_ch_a_i(ca[2]),
    .light_load_ch_a_i(ca[1]), .reference_range_error_ch_a_i(ca[0]),
    .shutdown_ch_b_i(cb[7]), .softstart_filter_active_ch_b_i(cb[6]), .primary_overcurrent_ch_b_i(cb[5]),
    .secondary_overcurrent_ch_b_i(cb[4]), .undervoltage_ch_b_i(cb[3]), .overvoltage_ch_b_i(cb[2]),
    .light_load_ch_b_i(cb[1]), .reference_range_error_ch_b_i(cb[0]),
    .supply_overvoltage_i(sy[6]), .shared_overcurrent_i(sy[5]), .overtemp_zone2_i(sy[4]),
    .overtemp_zone1_i(sy[3]), .ac_line_sense_low_i(sy[2]), .eeprom_checksum_error_i(sy[1]),
    .external_flag_sync_pin_i(sy[0]), .temp_warning_zone1_i(w1), .temp_warning_zone2_i(w2),
    .power_on_command_i(pon), .power_on_command_ch_a_i(pon_a), .power_on_command_ch_b_i(pon_b),
    .power_good_fault_ch_a_n_o(pg_n[0]), .power_good_fault_ch_b_n_o(pg_n[1]),
    .immediate_shutdown_o(shut), .restart_inhibit_o(inh));

  host_model host (.core_clk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // ========================================
  // settle, update model, read every bank
  task automatic step(input bit p);
    logic [DATA_W-1:0] nl[3];
    host.wr(LIVE_CH_A_OFS + 16'({$random(seed)} % 10), 8'($random(seed)));
    repeat (6) @(posedge core_clk_i);
    off_a = ca[7] | sy[1] | (off_a & ~pon_a);
    off_b = cb[7] | sy[1] | (off_b & ~pon_b);
    nl[0] = {off_a, ca[3] | off_a | sy[1] | ca[6] | (cfg[0] & sy[2]) | (cfg[1] & w1), ca[5:0]};
    nl[1] = {off_b, cb[3] | off_b | sy[1] | cb[6] | (cfg[2] & sy[2]) | (cfg[3] & w2), cb[5:0]};
    nl[2] = {1'h0, sy[6:0]};
    inh_m = inh_m | sy[6];
    for (int i = 0; i < 3; i++) begin
      lat[i] = lat[i] | (nl[i] & ~lv[i]);
      lv[i] = nl[i];
    end
    if (p) begin
      @(posedge core_clk_i) pon <= 1'h1;
      @(posedge core_clk_i) pon <= 1'h0;
      lat = '{default: '0};
      inh_m = sy[6];
    end
    for (int i = 0; i < 3; i++) begin
      host.rd(LIVE_CH_A_OFS + 16'(i), d);
      chk(d, lv[i]);
      host.rd(LATCH_CH_A_OFS + 16'(i), d);
      chk(d, lat[i]);
      lat[i] = lat[i] & lv[i];
    end
    chk({4'h0, pg_n, shut, inh}, {4'h0, ~lv[1][6], ~lv[0][6], sy[1], inh_m});
  endtask : step

  initial begin
    seed = 16;
    {ca, cb, sy, cfg, w1, w2, pon, pon_a, pon_b, off_a, off_b, inh_m} = '0;
    lv = '{default: '0};
    lat = '{default: '0};
    rst_i = 1'h1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 10; i++) begin
      host.rd(LIVE_CH_A_OFS + 16'(i), d);
      chk(d, 8'h00);
    end
    repeat (30) begin
      @(posedge core_clk_i) {ca[5:0], cb[5:0], sy[6:2], sy[0], w1, w2} <= 20'($random(seed));
      step(($random(seed) & 3) == 0);
    end
    @(posedge core_clk_i) ca[7] <= 1'h1;
    step(0);
    @(posedge core_clk_i) ca[7] <= 1'h0;
    step(1);
    @(posedge core_clk_i) pon_a <= 1'h1;
    step(0);
    @(posedge core_clk_i) {pon_a, sy[1]} <= 2'h1;
    step(0);
    @(posedge core_clk_i) {pon_a, pon_b, sy[1]} <= 3'h6;
    step(0);
    @(posedge core_clk_i) ca[5] <= 1'h0;
    step(0);
    fork
      host.rd(LATCH_CH_A_OFS, d);
      @(posedge core_clk_i) ca[5] <= 1'h1;
    join
    chk(d, lat[0]);
    lat[0] = lat[0] & lv[0];
    step(0);
    // soft-start terms and channel B shutdown, set beating a held power-on
    @(posedge core_clk_i) {ca[6], cb[7:6]} <= 3'h7;
    step(0);
    @(posedge core_clk_i) {ca[6], cb[7:6]} <= 3'h0;
    step(0);
    @(posedge core_clk_i) {pon_a, pon_b} <= 2'h0;
    host.wr(PG_CFG_OFS, 8'hff);
    host.rd(PG_CFG_OFS, d);
    chk(d, 8'h0f);
    cfg = 4'hf;
    @(posedge core_clk_i) {w1, w2, sy[2]} <= 3'h7;
    step(0);
    // random option values, so a swapped bit shows
    repeat (6) begin
      cfg = 4'($random(seed));
      host.wr(PG_CFG_OFS, {~cfg, cfg});
      host.rd(PG_CFG_OFS, d);
      chk(d, {4'h0, cfg});
      step(0);
      @(posedge core_clk_i) {w1, w2, sy[2]} <= 3'($random(seed));
      step(0);
    end
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge core_clk_i);
    fails++;
    stop_test();
  end
endmodule : fault_flag_status_bank_test
